// [hdl/qp_pkg.sv]
package qp_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned NV_WRITE_MS  = 20;
    // longest time, rounds down
    localparam int unsigned NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);

    // ==========================================================
    // register map
    localparam logic [3:0] ADDR_ACR      = 4'h8;
    localparam logic [3:0] ADDR_POT_LAST = 4'h3;
    localparam int         NUM_POTS      = 4;
    localparam int         BYTE_W        = 8;
    localparam int         WIPER_W       = 7;

    // ==========================================================
    // instruction opcodes (upper nibble)
    localparam logic [3:0] OP_READ  = 4'hB;
    localparam logic [3:0] OP_WRITE = 4'hC;

    // ==========================================================
    // access control fields and reset values
    localparam int         ACR_VOL_BIT  = 7;
    localparam int         ACR_SHUTDOWN_CONTROL_BIT = 6;
    localparam logic       VOL_RST      = 1'h0;
    localparam logic       SHUTDOWN_CONTROL_RST     = 1'h1;
    localparam logic [7:0] WIPER_RST    = 8'h40;
    localparam logic [7:0] PUV_RST      = 8'h40;

    // ==========================================================
    // frame position
    typedef enum logic [1:0] {
        FR_ID     = 2'h0,
        FR_INSTR  = 2'h1,
        FR_DATA   = 2'h3,
        FR_IGNORE = 2'h2
    } qp_frame_t;

endpackage

// [hdl/qp_spi_shift.sv]
`timescale 1ns/1ps
module qp_spi_shift (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic       sdi_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_data_i,
    output logic      [7:0] byte_o,
    output logic            byte_stb_o,
    output logic            cs_rise_o,
    output logic            sdo_o,
    output logic            sdo_oe_o
);
    // ==========================================================
    // edge detection
    logic       sck_q;
    logic       cs_n_q;
    logic [2:0] bit_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    wire        sck_rise = sck_i & ~sck_q & ~cs_n_i;
    wire        sck_fall = ~sck_i & sck_q & ~cs_n_i;
    wire  [7:0] rx_d     = {rx_q[6:0], sdi_i};
    wire        last_bit = (bit_q == 3'h7);

    // ==========================================================
    // receive, msb first on rising edges
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_q      <= 1'h0;
            cs_n_q     <= 1'h1;
            bit_q      <= 3'h0;
            rx_q       <= 8'h00;
            byte_o     <= 8'h00;
            byte_stb_o <= 1'h0;
            cs_rise_o  <= 1'h0;
        end else begin
            sck_q      <= sck_i;
            cs_n_q     <= cs_n_i;
            byte_stb_o <= sck_rise & last_bit;
            cs_rise_o  <= cs_n_i & ~cs_n_q;
            if (cs_n_i) begin
                bit_q <= 3'h0;
            end else if (sck_rise) begin
                bit_q <= bit_q + 3'h1;
                rx_q  <= rx_d;
                if (last_bit) begin
                    byte_o <= rx_d;
                end
            end
        end
    end

    // ==========================================================
    // transmit, msb first on falling edges
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_q     <= 8'h00;
            sdo_o    <= 1'h0;
            sdo_oe_o <= 1'h0;
        end else begin
            sdo_oe_o <= ~cs_n_i;
            if (cs_n_i) begin
                sdo_o <= 1'h0;
                tx_q  <= 8'h00;
            end else if (load_i) begin
                tx_q <= load_data_i;
            end else if (sck_fall) begin
                sdo_o <= tx_q[7];
                tx_q  <= {tx_q[6:0], 1'h0};
            end
        end
    end

    AST_SDO_ON_FALL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !cs_n_i && $changed(sdo_o) |-> $past(sck_fall))
        else $error("sdo changed without a falling sck");

endmodule

// [hdl/qp_nv_timer.sv]
`timescale 1ns/1ps
module qp_nv_timer #(
    parameter int unsigned CYCLES = qp_pkg::NV_WRITE_CYC
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic start_i,
    output logic      busy_o
);
    localparam int CW = $clog2(CYCLES + 1);

    if (CYCLES < 1) begin : g_chk
        $error("CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt_q;

    // ==========================================================
    // busy for exactly CYCLES clocks
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= '0;
            busy_o <= 1'h0;
        end else if (start_i && !busy_o) begin
            cnt_q  <= CW'(CYCLES - 1);
            busy_o <= 1'h1;
        end else if (busy_o) begin
            if (cnt_q == '0) begin
                busy_o <= 1'h0;
            end else begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

endmodule

// [hdl/qp_regs.sv]
`timescale 1ns/1ps
// Functional notes
// - access control register decoded at address 8
// - addresses 0-3 select pots 0-3
// - wiper output follows wiper register only
// - select bit 1: volatile wiper access only
// - select bit 0: power-up value registers accessed
// - power-up value write sets puv_q; reset reloads PUV_RST, so recall restores 0x40
// - power-up value write also loads wiper
// - reads never change wiper registers
// - read: data shifted out in third byte
// - opcode 1011 read, 1100 write, else invalid
// - nv write starts at cs rise, flagged busy
// - writes ignored while write in progress
// - spi mode 0, msb first
module qp_regs #(
    parameter int unsigned NV_WRITE_CYCLES = qp_pkg::NV_WRITE_CYC,
    parameter logic [3:0]  DEVICE_ID       = 4'hA  // value arbitrary
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic       sdi_i,
    input  wire logic       shutdown_control_n_i,
    output logic            sdo_o,
    output logic            sdo_oe_o,
    output logic      [6:0] wiper0_o,
    output logic      [6:0] wiper1_o,
    output logic      [6:0] wiper2_o,
    output logic      [6:0] wiper3_o,
    output logic            shutdown_o,
    output logic            write_in_progress_o
);
    // ==========================================================
    // declarations
    logic [7:0]        wiper_q [qp_pkg::NUM_POTS];
    logic [7:0]        puv_q   [qp_pkg::NUM_POTS];
    logic              vol_q;
    logic              shutdown_control_q;
    logic              shut_q;
    logic              recall_q;
    logic              op_rd_q;
    logic [3:0]        addr_q;
    logic              nv_pend_q;
    logic [1:0]        nv_addr_q;
    logic [7:0]        nv_data_q;
    qp_pkg::qp_frame_t st_q;
    qp_pkg::qp_frame_t st_d;
    logic [7:0]        rx_byte;
    logic              byte_stb;
    logic              cs_rise;
    logic              write_in_progress;

    function automatic logic is_pot(input logic [3:0] a);
        return a <= qp_pkg::ADDR_POT_LAST;
    endfunction

    // busy check below needs at least eight busy cycles
    if (NV_WRITE_CYCLES < 8) begin : g_chk
        $error("NV_WRITE_CYCLES must be at least 8");
    end

    // ==========================================================
    // decoding
    wire [7:0] id_byte    = {DEVICE_ID, 4'h0};
    wire [3:0] instr_op   = rx_byte[7:4];
    wire [3:0] instr_addr = rx_byte[3:0];
    wire       op_is_rd   = (instr_op == qp_pkg::OP_READ);
    wire       op_is_wr   = (instr_op == qp_pkg::OP_WRITE);
    wire       op_ok      = op_is_rd | op_is_wr;
    wire [1:0] pot_sel    = instr_addr[1:0];
    wire [7:0] acr_val    = {vol_q, shutdown_control_q, write_in_progress, 5'h00};
    // select bit picks volatile or power-up set
    wire [7:0] pot_rd     = vol_q ? wiper_q[pot_sel]
                                  : puv_q[pot_sel];
    wire       rd_is_acr  = (instr_addr == qp_pkg::ADDR_ACR);
    wire [7:0] tx_data    = is_pot(instr_addr) ? pot_rd
                          : rd_is_acr ? acr_val : 8'h00;
    wire       in_instr   = (st_q == qp_pkg::FR_INSTR);
    wire       in_data    = (st_q == qp_pkg::FR_DATA);
    wire       tx_load    = in_instr & byte_stb & op_is_rd;
    wire       wr_try     = in_data & byte_stb & ~op_rd_q;
    wire       wr_fire    = wr_try & ~write_in_progress;
    wire       wr_acr     = wr_fire & (addr_q == qp_pkg::ADDR_ACR);
    wire       wr_pot     = wr_fire & is_pot(addr_q);
    wire       nv_start   = cs_rise & nv_pend_q;

    // ==========================================================
    // serial port
    qp_spi_shift u_shift (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .sck_i       (sck_i),
        .cs_n_i      (cs_n_i),
        .sdi_i       (sdi_i),
        .load_i      (tx_load),
        .load_data_i (tx_data),
        .byte_o      (rx_byte),
        .byte_stb_o  (byte_stb),
        .cs_rise_o   (cs_rise),
        .sdo_o       (sdo_o),
        .sdo_oe_o    (sdo_oe_o)
    );

    // ==========================================================
    // non-volatile write timer
    qp_nv_timer #(
        .CYCLES (NV_WRITE_CYCLES)
    ) u_timer (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .start_i (nv_start),
        .busy_o  (write_in_progress)
    );

    // ==========================================================
    // frame sequencing
    always_comb begin
        st_d = st_q;
        if (cs_n_i) begin
            st_d = qp_pkg::FR_ID;
        end else if (byte_stb) begin
            case (st_q)
                qp_pkg::FR_ID: begin
                    st_d = (rx_byte == id_byte) ? qp_pkg::FR_INSTR
                                                : qp_pkg::FR_IGNORE;
                end
                qp_pkg::FR_INSTR: begin
                    st_d = op_ok ? qp_pkg::FR_DATA
                                 : qp_pkg::FR_IGNORE;
                end
                qp_pkg::FR_DATA: begin
                    st_d = qp_pkg::FR_IGNORE;
                end
                default: begin
                    st_d = qp_pkg::FR_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q    <= qp_pkg::FR_ID;
            op_rd_q <= 1'h0;
            addr_q  <= 4'h0;
        end else begin
            st_q <= st_d;
            if (in_instr && byte_stb) begin
                op_rd_q <= op_is_rd;
                addr_q  <= instr_addr;
            end
        end
    end

    // ==========================================================
    // access control register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vol_q  <= qp_pkg::VOL_RST;
            shutdown_control_q <= qp_pkg::SHUTDOWN_CONTROL_RST;
            shut_q <= 1'h0;
        end else begin
            shut_q <= ~(shutdown_control_n_i & shutdown_control_q);
            if (wr_acr) begin
                vol_q  <= rx_byte[qp_pkg::ACR_VOL_BIT];
                shutdown_control_q <= rx_byte[qp_pkg::ACR_SHUTDOWN_CONTROL_BIT];
            end
        end
    end

    // ==========================================================
    // pending non-volatile write
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nv_pend_q <= 1'h0;
            nv_addr_q <= 2'h0;
            nv_data_q <= 8'h00;
        end else if (wr_pot && !vol_q) begin
            nv_pend_q <= 1'h1;
            nv_addr_q <= addr_q[1:0];
            nv_data_q <= rx_byte;
        end else if (cs_rise) begin
            nv_pend_q <= 1'h0;
        end
    end

    // ==========================================================
    // wiper and power-up value storage
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            recall_q <= 1'h1;
        end else begin
            recall_q <= 1'h0;
        end
    end

    for (genvar i = 0; i < qp_pkg::NUM_POTS; i++) begin : g_pot
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                wiper_q[i] <= qp_pkg::WIPER_RST;
                puv_q[i]   <= qp_pkg::PUV_RST;
            end else begin
                if (recall_q) begin
                    wiper_q[i] <= puv_q[i];
                end else if (wr_pot && addr_q[1:0] == 2'(i)) begin
                    wiper_q[i] <= rx_byte;
                end
                if (nv_start && nv_addr_q == 2'(i)) begin
                    puv_q[i] <= nv_data_q;
                end
            end
        end
    end

    // ==========================================================
    // outputs
    assign wiper0_o            = wiper_q[0][qp_pkg::WIPER_W-1:0];
    assign wiper1_o            = wiper_q[1][qp_pkg::WIPER_W-1:0];
    assign wiper2_o            = wiper_q[2][qp_pkg::WIPER_W-1:0];
    assign wiper3_o            = wiper_q[3][qp_pkg::WIPER_W-1:0];
    assign shutdown_o          = shut_q;
    assign write_in_progress_o = write_in_progress;

    // ==========================================================
    // checks
    wire [31:0] wiper_all = {wiper_q[3], wiper_q[2], wiper_q[1], wiper_q[0]};
    wire [31:0] puv_all   = {puv_q[3], puv_q[2], puv_q[1], puv_q[0]};

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_ACR_READ: assert property (
        tx_load && !cs_n_i && rd_is_acr
        |=> u_shift.tx_q == {$past(vol_q), $past(shutdown_control_q), $past(write_in_progress), 5'h00})
        else $error("access control read value wrong");

    AST_POT_ADDR: assert property (
        wr_pot && vol_q |=> wiper_q[$past(addr_q[1:0])] == $past(rx_byte))
        else $error("wiper write went to wrong pot");

    AST_WIPER_CAUSE: assert property (
        $changed(wiper_all) |-> $past(wr_pot) || $past(recall_q))
        else $error("wiper changed without a write");

    AST_VOL_NO_NV: assert property (
        wr_pot && vol_q && !nv_pend_q |=> !nv_pend_q ##1 $stable(puv_all))
        else $error("volatile write touched power-up storage");

    AST_NV_READ: assert property (
        tx_load && !cs_n_i && !vol_q && is_pot(instr_addr)
        |=> u_shift.tx_q == $past(puv_q[pot_sel]))
        else $error("power-up value read wrong");

    AST_NV_COMMIT: assert property (
        nv_start |=> puv_q[$past(nv_addr_q)] == $past(nv_data_q))
        else $error("power-up value not stored");

    AST_MIRROR: assert property (
        wr_pot && !vol_q |=> wiper_q[$past(addr_q[1:0])] == $past(rx_byte))
        else $error("wiper not loaded with power-up value");

    AST_READ_KEEPS: assert property (
        op_rd_q && st_q != qp_pkg::FR_ID && !recall_q |=> $stable(wiper_all))
        else $error("read changed a wiper");

    AST_BAD_OP: assert property (
        in_instr && byte_stb && !cs_n_i && !op_ok |=> st_q == qp_pkg::FR_IGNORE)
        else $error("invalid opcode accepted");

    AST_WIP_SET: assert property (
        nv_start && !write_in_progress |=> write_in_progress [*8])
        else $error("write in progress not held");

    AST_WIP_BLOCK: assert property (
        wr_try && write_in_progress |=> $stable(wiper_all) && $stable(vol_q) && $stable(shutdown_control_q))
        else $error("write accepted while busy");

    AST_ACR_WRITE: assert property (
        wr_acr |=> vol_q == $past(rx_byte[7]) && shutdown_control_q == $past(rx_byte[6]))
        else $error("access control write lost");

    AST_NV_PEND: assert property (
        wr_pot && !vol_q |=> nv_pend_q && nv_addr_q == $past(addr_q[1:0]) && nv_data_q == $past(rx_byte))
        else $error("power-up write not queued");

    AST_WIP_IDLE: assert property (
        !write_in_progress && !nv_start |=> !write_in_progress)
        else $error("write in progress without start");

    AST_IGNORE_STAYS: assert property (
        st_q == qp_pkg::FR_IGNORE && !cs_n_i |=> st_q == qp_pkg::FR_IGNORE)
        else $error("ignored frame resumed");

    COV_READ: cover property (tx_load ##[1:200] cs_rise);
    COV_NV_WRITE: cover property (nv_start);
    COV_VOL_READ: cover property (tx_load && vol_q && is_pot(instr_addr));
    COV_BUSY_WRITE: cover property (wr_try && write_in_progress);
    COV_BAD_ID: cover property (st_q == qp_pkg::FR_ID && byte_stb && rx_byte != id_byte);

endmodule

// [bench/qp_spi_host.sv]
`timescale 1ns/1ps
// ==========================================================
// spi host model, mode 0, driven on mclk falling edges
module qp_spi_host (
    input  wire logic       mclk_i,
    input  wire logic       sdo_i,
    output logic            cs_n_o,
    output logic            sck_o,
    output logic            sdi_o,
    output logic      [7:0] rx_o,
    output logic            done_o
);
    logic idle_q = 1'b0;
    logic bit_q  = 1'b0;

    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        rx_o   = 8'h00;
        done_o = 1'b0;
    end

    // released line shows a changing pattern
    always @(negedge mclk_i) begin
        idle_q <= ~idle_q;
    end
    assign sdi_o = cs_n_o ? idle_q : bit_q;

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    // id, instruction, data; half = mclk cycles per sck level
    task automatic frame(input logic [7:0] id_b, input logic [7:0] ins_b, input logic [7:0] dat_b,
                         input int half, input logic rd);
        logic [23:0] sh;
        int          i;
        sh = {id_b, ins_b, dat_b};
        cs_n_o = 1'b0;
        wait_n(2);
        for (i = 23; i >= 0; i--) begin
            bit_q = sh[i];
            wait_n(half);
            sck_o = 1'b1;
            if (i < 8) begin
                rx_o = {rx_o[6:0], sdo_i};
            end
            wait_n(half);
            sck_o = 1'b0;
        end
        wait_n(half);
        cs_n_o = 1'b1;
        wait_n(3);
        if (rd) begin
            done_o = 1'b1;
            wait_n(1);
            done_o = 1'b0;
        end
    endtask
endmodule

// [bench/qp_regs_tb.sv]
`timescale 1ns/1ps
module qp_regs_tb;
    localparam int unsigned NVC    = 2000;
    localparam logic [3:0]  DEV_ID = 4'h6; // value arbitrary
    localparam logic [7:0]  ID_B   = {DEV_ID, 4'h0};
    localparam int          LIMIT  = 40000;

    logic       mclk_i   = 1'b0;
    logic       rst_n_i  = 1'b0;
    logic       shutdown_control_n_i = 1'b1;
    logic       cs_n, sck, sdi, sdo, sdo_oe, shutdown, write_in_progress, done;
    logic [7:0] rx;
    logic [6:0] wiper [4];
    logic [7:0] exp_q [$];
    logic [7:0] v [4];
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         k;

    always #50 mclk_i = ~mclk_i;

    qp_spi_host qp_spi_host_inst (
        .mclk_i (mclk_i),
        .sdo_i  (sdo),
        .cs_n_o (cs_n),
        .sck_o  (sck),
        .sdi_o  (sdi),
        .rx_o   (rx),
        .done_o (done)
    );

    qp_regs #(.NV_WRITE_CYCLES(NVC), .DEVICE_ID(DEV_ID)) qp_regs_inst (
        .mclk_i              (mclk_i),
        .rst_n_i             (rst_n_i),
        .cs_n_i              (cs_n),
        .sck_i               (sck),
        .sdi_i               (sdi),
        .shutdown_control_n_i            (shutdown_control_n_i),
        .sdo_o               (sdo),
        .sdo_oe_o            (sdo_oe),
        .wiper0_o            (wiper[0]),
        .wiper1_o            (wiper[1]),
        .wiper2_o            (wiper[2]),
        .wiper3_o            (wiper[3]),
        .shutdown_o          (shutdown),
        .write_in_progress_o (write_in_progress)
    );

    // ==========================================================
    // checking and closing
    task automatic report_and_stop();
        $display("errors %0d, compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_wip(input int n, input logic [7:0] exp);
        cmp_byte({1'b0, wiper[n]}, {1'b0, exp[6:0]}, "wiper");
    endtask

    // ==========================================================
    // register access through the host model
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input int half);
        qp_spi_host_inst.frame(ID_B, {qp_pkg::OP_WRITE, a}, d, half, 1'b0);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input int half);
        exp_q.push_back(exp);
        qp_spi_host_inst.frame(ID_B, {qp_pkg::OP_READ, a}, 8'($urandom), half, 1'b1);
    endtask

    always @(posedge mclk_i) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp_bit(1'b1, 1'b0, "unexpected read");
            end else begin
                cmp_byte(rx, exp_q.pop_front(), "read data");
            end
        end
    end

    always @(posedge sck) begin
        cmp_bit(sdo_oe, 1'b1, "sdo drive enable");
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc >= LIMIT) begin
            err_total++;
            report_and_stop();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        k = $urandom(46);
        repeat (12) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        for (k = 0; k < 4; k++) begin
            chk_wip(k, 8'h40);
        end
        cmp_bit(write_in_progress, 1'b0, "wip after reset");
        cmp_bit(shutdown, 1'b0, "shutdown after reset");
        cmp_bit(sdo_oe, 1'b0, "sdo idle after reset");
        rd(4'h8, 8'h40, 5);
        wr(4'h8, 8'hC0, 5);
        for (k = 0; k < 4; k++) begin
            v[k] = 8'($urandom) & 8'h7F;
            wr(4'(k), v[k], (k % 2) ? 9 : 5);
            chk_wip(k, v[k]);
            cmp_bit(write_in_progress, 1'b0, "volatile write busy");
        end
        for (k = 0; k < 4; k++) begin
            rd(4'(k), v[k], 5);
        end
        rd(4'h8, 8'hC0, 5);
        wr(4'h8, 8'h40, 5);
        wr(4'h2, 8'h77, 5);
        chk_wip(2, 8'h77);
        cmp_bit(write_in_progress, 1'b1, "nv write busy");
        wr(4'h2, 8'h22, 5);
        wr(4'h8, 8'hC0, 5);
        chk_wip(2, 8'h77);
        rd(4'h8, 8'h60, 5);
        for (k = 0; k < 3000 && write_in_progress !== 1'b0; k++) begin
            @(negedge mclk_i);
        end
        cmp_bit(write_in_progress, 1'b0, "nv write end");
        rd(4'h2, 8'h77, 5);
        wr(4'h8, 8'hC0, 5);
        wr(4'h2, 8'h11, 5);
        chk_wip(2, 8'h11);
        wr(4'h8, 8'h40, 5);
        rd(4'h2, 8'h77, 9);
        chk_wip(2, 8'h11);
        for (k = 0; k < 16; k++) begin
            if (k != 11 && k != 12) begin
                qp_spi_host_inst.frame(ID_B, {4'(k), 4'h1}, 8'h5A, 5, 1'b0);
            end
        end
        qp_spi_host_inst.frame({~DEV_ID, 4'h0}, {qp_pkg::OP_WRITE, 4'h1}, 8'h5A, 5, 1'b0);
        chk_wip(1, v[1]);
        rd(4'h9, 8'h00, 5);
        wr(4'h9, 8'hC0, 5);
        wr(4'h5, 8'h33, 5);
        rd(4'h8, 8'h40, 5);
        shutdown_control_n_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        cmp_bit(shutdown, 1'b1, "shutdown pin");
        shutdown_control_n_i = 1'b1;
        wr(4'h8, 8'h80, 5);
        cmp_bit(shutdown, 1'b1, "shutdown bit");
        repeat (20) @(negedge mclk_i);
        report_and_stop();
    end
endmodule
